// >>> bus_status_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Reset indicator stays high while the reset request input is low.
// - Top status line low: interrupt ack, I/O read, I/O write, halt.
// - Top status line high: fetch, memory read, memory write, all-ones idle.
// - Write strobe low only while write data is valid on the bus.
// - WAIT stalls while the release input is high, resumes when low.
// - Upper chip select low for memory cycles inside its programmed range.
// - Reset request aborts any running cycle and sets known pin levels.
// - Ready ends a cycle, ignored when the chip select handles it.
// - Read strobe low requests data from the addressed device.
module bus_status_ctrl #(
   parameter int                        ADDR_W   = bus_pins_pkg::ADDR_W,
   parameter logic [ADDR_W-1:0]         UCS_BASE = 20'hF_0000
) (
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   input  wire logic                    reset_req_n,
   input  wire logic                    ready,
   input  wire logic                    wait_release_n,
   input  wire logic                    wait_exec,
   input  wire bus_pins_pkg::bus_req_t  req,
   output var  logic                    req_taken,
   output var  logic                    cycle_done,
   output var  logic                    wait_stall,
   output var  logic                    reset_out,
   output var  bus_pins_pkg::pin_out_t  pins
);
   // ****************************************
   // Reset indication
   // ****************************************
   logic in_reset_r;

   reset_sync reset_sync_i (
      .core_clk    (core_clk),
      .rst         (rst),
      .reset_req_n (reset_req_n),
      .in_reset_r  (in_reset_r)
   );

   logic abort;
   assign abort = rst | ~reset_req_n;

   // ****************************************
   // Bus cycle sequencer
   // ****************************************
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} state_t;
   state_t                    state_r;
   bus_pins_pkg::cycle_code_t code_r;
   logic                      ucs_hit_r;
   logic                      is_mem, is_write, is_read, hit;

   assign is_mem   = req.code inside {bus_pins_pkg::CYC_FETCH, bus_pins_pkg::CYC_MEMRD,
                                      bus_pins_pkg::CYC_MEMWR};
   assign hit      = is_mem && (req.addr >= UCS_BASE);
   assign is_write = (code_r == bus_pins_pkg::CYC_MEMWR) || (code_r == bus_pins_pkg::CYC_IOWR);
   assign is_read  = (code_r == bus_pins_pkg::CYC_MEMRD) || (code_r == bus_pins_pkg::CYC_IORD)
                     || (code_r == bus_pins_pkg::CYC_FETCH) || (code_r == bus_pins_pkg::CYC_INTA);

   logic start;
   assign start = (state_r == ST_IDLE) && req.valid && !in_reset_r && !abort;

   always_ff @(posedge core_clk) begin
      if (abort) begin
         state_r   <= ST_IDLE;
         code_r    <= bus_pins_pkg::CYC_IDLE;
         ucs_hit_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r   <= ST_ADDR;
                  code_r    <= req.code;
                  ucs_hit_r <= hit;
               end
            end
            ST_ADDR: begin
               state_r <= ST_DATA;
            end
            ST_DATA: begin
               if (ucs_hit_r || ready || code_r == bus_pins_pkg::CYC_HALT) begin
                  state_r <= ST_IDLE;
                  code_r  <= bus_pins_pkg::CYC_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   logic ending;
   assign ending = (state_r == ST_DATA)
                   && (ucs_hit_r || ready || code_r == bus_pins_pkg::CYC_HALT);

   always_ff @(posedge core_clk) begin
      if (abort) begin
         req_taken  <= 1'b0;
         cycle_done <= 1'b0;
      end else begin
         req_taken  <= start;
         cycle_done <= ending;
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (abort || in_reset_r) begin
         pins <= '{default: 1'b1};
      end else begin
         {pins.cycle_type_bit2_n, pins.cycle_type_bit1_n, pins.cycle_type_bit0_n} <=
            (start) ? req.code :
            (state_r != ST_IDLE && !ending) ? code_r :
            bus_pins_pkg::STATUS_RESET;
         pins.wr_n  <= !((state_r == ST_ADDR || (state_r == ST_DATA && !ending)) && is_write);
         pins.rd_n  <= !((state_r == ST_ADDR || (state_r == ST_DATA && !ending)) && is_read);
         pins.ucs_n <= start ? !hit : !((state_r != ST_IDLE) && !ending && ucs_hit_r);
      end
   end

   // ****************************************
   // WAIT instruction stall
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (abort) begin
         wait_stall <= 1'b0;
      end else begin
         wait_stall <= wait_exec && wait_release_n;
      end
   end

   // ****************************************
   // Reset indicator output
   // ****************************************
   // reset indicator out
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reset_out <= 1'b1;
      end else begin
         reset_out <= in_reset_r | ~reset_req_n;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_rst_out;
      @(posedge core_clk) disable iff (rst) !reset_req_n |=> ##1 reset_out;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset_out low during reset request");

   property p_idle_code;
      @(posedge core_clk) disable iff (rst) state_r == ST_IDLE && !start
         |=> {pins.cycle_type_bit2_n, pins.cycle_type_bit1_n, pins.cycle_type_bit0_n} == 3'h7;
   endproperty
   a_idle_code: assert property (p_idle_code) else $error("status not idle");

   property p_code_match;
      @(posedge core_clk) disable iff (abort) start
         |=> {pins.cycle_type_bit2_n, pins.cycle_type_bit1_n, pins.cycle_type_bit0_n} == $past(req.code);
   endproperty
   a_code_match: assert property (p_code_match) else $error("status code mismatch");

   property p_wr_valid;
      @(posedge core_clk) disable iff (rst) !pins.wr_n |-> is_write && state_r != ST_IDLE;
   endproperty
   a_wr_valid: assert property (p_wr_valid) else $error("write strobe without write");

   property p_rd_valid;
      @(posedge core_clk) disable iff (rst) !pins.rd_n |-> is_read && state_r != ST_IDLE;
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read strobe without read");

   property p_wait;
      @(posedge core_clk) disable iff (abort) wait_exec && wait_release_n |=> wait_stall;
   endproperty
   a_wait: assert property (p_wait) else $error("wait not stalled");

   property p_wait_resume;
      @(posedge core_clk) disable iff (abort) !wait_release_n |=> !wait_stall;
   endproperty
   a_wait_resume: assert property (p_wait_resume) else $error("wait not released");

   property p_ucs;
      @(posedge core_clk) disable iff (abort || in_reset_r) start && hit |=> !pins.ucs_n;
   endproperty
   a_ucs: assert property (p_ucs) else $error("chip select missing");

   property p_ucs_miss;
      @(posedge core_clk) disable iff (abort || in_reset_r) start && !hit |=> pins.ucs_n;
   endproperty
   a_ucs_miss: assert property (p_ucs_miss) else $error("chip select outside range");

   property p_ucs_ready;
      @(posedge core_clk) disable iff (abort) state_r == ST_DATA && ucs_hit_r |=> state_r == ST_IDLE;
   endproperty
   a_ucs_ready: assert property (p_ucs_ready) else $error("chip select cycle waited on ready");

   sequence s_cycle_cleared;
      state_r == ST_IDLE;
   endsequence

   sequence s_strobes_released;
      pins.wr_n && pins.rd_n;
   endsequence

   property p_abort;
      @(posedge core_clk) !reset_req_n |=> s_cycle_cleared ##1 s_strobes_released;
   endproperty
   a_abort: assert property (p_abort) else $error("cycle not aborted");

   property p_reset_pins;
      @(posedge core_clk) disable iff (rst) reset_out |-> pins == 6'h3f;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("strobe active in reset");

   property p_strobe_excl;
      @(posedge core_clk) disable iff (rst) !(!pins.wr_n && !pins.rd_n);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes together");
endmodule
`default_nettype wire

// >>> bus_pins_pkg.sv
package bus_pins_pkg;

   // ****************************************
   // Cycle type codes (active-low lines)
   // ****************************************
   typedef enum logic [2:0] {
      CYC_INTA  = 3'h0,
      CYC_IORD  = 3'h1,
      CYC_IOWR  = 3'h2,
      CYC_HALT  = 3'h3,
      CYC_FETCH = 3'h4,
      CYC_MEMRD = 3'h5,
      CYC_MEMWR = 3'h6,
      CYC_IDLE  = 3'h7
   } cycle_code_t;

   localparam logic [2:0] STATUS_RESET = 3'h7;
   localparam int         ADDR_W       = 20;

   // ****************************************
   // Bus request from the execution core
   // ****************************************
   typedef struct packed {
      logic              valid;
      cycle_code_t       code;
      logic [ADDR_W-1:0] addr;
   } bus_req_t;

   typedef struct packed {
      logic cycle_type_bit2_n;
      logic cycle_type_bit1_n;
      logic cycle_type_bit0_n;
      logic rd_n;
      logic wr_n;
      logic ucs_n;
   } pin_out_t;

endpackage

// >>> reset_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Registers the reset request into in_reset_r; the reset indicator is registered in bus_status_ctrl.
module reset_sync (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic reset_req_n,
   output var  logic in_reset_r
);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         in_reset_r <= 1'b1;
      end else begin
         in_reset_r <= ~reset_req_n;
      end
   end
endmodule
`default_nettype wire

// >>> bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire bus_pins_pkg::pin_out_t pins,
   input  wire logic [3:0]             lag,
   output var  logic                   ready
);
   logic [3:0] cnt_r;
   always_ff @(posedge core_clk) begin
      if (rst || pins[5:3] == 3'h7 || !pins[0] || ready) begin
         cnt_r <= 4'h0;
         ready <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
         ready <= (cnt_r == lag);
      end
   end
endmodule
`default_nettype wire

// >>> bus_status_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bus_status_ctrl_tb;
   logic                    core_clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    reset_req_n = 1'b1;
   logic                    ready;
   logic                    wait_release_n = 1'b1;
   logic                    wait_exec = 1'b0;
   bus_pins_pkg::bus_req_t  req = '0;
   logic                    req_taken;
   logic                    cycle_done;
   logic                    wait_stall;
   logic                    reset_out;
   bus_pins_pkg::pin_out_t  pins;
   logic [3:0]              lag = 4'h0;
   int                      err_count = 0;
   int                      total_checks = 0;
   int                      cyc = 0;
   always #2.5 core_clk = ~core_clk;
   bus_status_ctrl bus_status_ctrl_i (.core_clk(core_clk), .rst(rst), .reset_req_n(reset_req_n),
      .ready(ready), .wait_release_n(wait_release_n), .wait_exec(wait_exec), .req(req),
      .req_taken(req_taken), .cycle_done(cycle_done), .wait_stall(wait_stall),
      .reset_out(reset_out), .pins(pins));
   bus_partner bus_partner_i (.core_clk(core_clk), .rst(rst), .pins(pins), .lag(lag), .ready(ready));
   task chk(input string what, input logic [5:0] seen, input logic [5:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wrap_up;
      if (err_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         wrap_up;
      end
   end
   task run_cycle(input logic [2:0] code, input logic [19:0] addr, input logic [3:0] dly);
      logic [5:0] exp;
      int n;
      exp = {code, !(code inside {1, 4, 5}), !(code inside {2, 6}),
             !(code inside {4, 5, 6} && addr >= 20'hF_0000)};
      @(posedge core_clk);
      lag <= dly;
      req <= {1'b1, bus_pins_pkg::cycle_code_t'(code), addr};
      for (n = 0; n < 20 && req_taken !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      chk("taken", {5'h0, req_taken}, 6'h01);
      @(posedge core_clk);
      req.valid <= 1'b0;
      #1;
      chk("pins", (code == 0 || code == 3) ? {pins[5:3], exp[2:0]} : pins, exp);
      if (dly > 4 && exp[0]) begin
         @(posedge core_clk);
         #1;
         chk("pins held", pins, exp);
      end
      for (n = 0; n < 40 && cycle_done !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      chk("done", {5'h0, cycle_done}, 6'h01);
      chk("idle", pins, 6'h3f);
   endtask
   task reset_scn;
      run_cycle(3'h5, 20'h0_0100, 4'hf);
      @(posedge core_clk);
      lag <= 4'hf;
      req <= {1'b1, bus_pins_pkg::CYC_MEMWR, 20'h0_0200};
      repeat (3) @(posedge core_clk);
      req.valid <= 1'b0;
      reset_req_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("abort", pins, 6'h3f);
      chk("rst out", {5'h0, reset_out}, 6'h01);
      repeat (10) @(posedge core_clk);
      #1;
      chk("rst out hold", {5'h0, reset_out}, 6'h01);
      chk("pins hold", pins, 6'h3f);
      @(posedge core_clk);
      reset_req_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk("rst out off", {5'h0, reset_out}, 6'h00);
      run_cycle(3'h6, 20'hF_8000, 4'h0);
   endtask
   task wait_scn;
      @(posedge core_clk);
      wait_exec <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk("stall", {5'h0, wait_stall}, 6'h01);
      @(posedge core_clk);
      wait_release_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("resume", {5'h0, wait_stall}, 6'h00);
      @(posedge core_clk);
      wait_exec <= 1'b0;
      wait_release_n <= 1'b1;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("rst idle", {reset_out, pins[5:1]}, 6'h1f);
      for (int c = 0; c < 7; c++)
         run_cycle(c[2:0], 20'h0_1234, 4'h1);
      run_cycle(3'h5, 20'hF_0000, 4'h1);
      run_cycle(3'h5, 20'hE_FFFF, 4'h6);
      run_cycle(3'h6, 20'hF_FFFF, 4'hf);
      run_cycle(3'h2, 20'hF_FFFF, 4'h6);
      reset_scn;
      wait_scn;
      wrap_up;
   end
endmodule
`default_nettype wire
